//--- ptu_map.vh
// register map, field positions and reset values of the protocol timer unit
`ifndef PTU_MAP_VH
`define PTU_MAP_VH

// ------------------------------------------------------------
// register indices (byte address = 4 * index)
// ------------------------------------------------------------
`define PTU_IDX_MODE          8'h2A
`define PTU_IDX_PRESC         8'h2B
`define PTU_IDX_RELOAD_HI     8'h2C
`define PTU_IDX_RELOAD_LO     8'h2D
`define PTU_IDX_COUNT_HI      8'h2E
`define PTU_IDX_COUNT_LO      8'h2F
`define PTU_IDX_CONFIG        8'h40
`define PTU_IDX_COMMAND       8'h41
`define PTU_IDX_STATE         8'h42
`define PTU_IDX_IRQ_STATUS    8'h43
`define PTU_IDX_IRQ_MASK      8'h44

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define PTU_MODE_AUTO_BIT     7
`define PTU_MODE_GATE_HI      6
`define PTU_MODE_GATE_LO      5
`define PTU_MODE_RELOAD_BIT   4
`define PTU_MODE_PRE_HI       3
`define PTU_MODE_PRE_LO       0

// gate source codes
`define PTU_GATE_SIGNAL_IN    2'h1
`define PTU_GATE_AUX_ONE      2'h2
`define PTU_GATE_ADDR_THREE   2'h3

// ------------------------------------------------------------
// config, command, state and interrupt fields
// ------------------------------------------------------------
`define PTU_CFG_RX_MULTI_BIT  0
`define PTU_CFG_EVEN_DIV_BIT  1
`define PTU_CFG_INIT_RF_BIT   2
`define PTU_CMD_STOP_BIT      0
`define PTU_CMD_START_BIT     1
`define PTU_ST_RUNNING_BIT    0
`define PTU_IRQ_EXPIRY_BIT    0
`define PTU_IRQ_START_BIT     1
`define PTU_IRQ_RXSTOP_BIT    2
`define PTU_IRQ_WIDTH         3

// ------------------------------------------------------------
// reset values and protocol counts
// ------------------------------------------------------------
`define PTU_RST_BYTE          8'h00
`define PTU_RST_IRQ           3'h0
`define PTU_RX_STOP_106       3'h5
`define PTU_RX_STOP_OTHER     3'h4

`endif

//--- ptu_prescaler.v
// prescaler that turns the system clock into one-cycle timer ticks
`timescale 1ns/1ps
`default_nettype none

module ptu_prescaler #(
   parameter PRE_W = 12
) (
   // clock and reset
   input  wire             mclk_in,
   input  wire             rst_n_in,
   // control
   input  wire             run_in,
   input  wire             restart_in,
   input  wire             even_in,
   input  wire [PRE_W-1:0] presc_in,
   // tick
   output wire             tick_out
);

   reg  [PRE_W:0] div_cnt_r;
   wire [PRE_W:0] div_last;

   // odd divide is 2p+1 cycles, even divide 2p+2; the count runs last..0
   assign div_last = {presc_in, even_in};
   assign tick_out = run_in & ~restart_in & (div_cnt_r == {(PRE_W+1){1'b0}});

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_cnt_r <= {(PRE_W+1){1'b0}};
      end else if (restart_in || !run_in) begin
         div_cnt_r <= div_last;
      end else if (div_cnt_r == {(PRE_W+1){1'b0}}) begin
         div_cnt_r <= div_last;
      end else begin
         div_cnt_r <= div_cnt_r - {{PRE_W{1'b0}}, 1'b1};
      end
   end

endmodule

`default_nettype wire

//--- ptu_timer.v
// protocol timer unit: avalon register slave, start/stop logic and 16-bit down counter
`timescale 1ns/1ps
`default_nettype none

`include "ptu_map.vh"

module ptu_timer #(
   parameter CNT_W = 16,
   parameter PRE_W = 12
) (
   // clock and reset
   input  wire        mclk_in,
   input  wire        rst_n_in,
   // avalon-mm slave
   input  wire [9:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output wire        avs_waitrequest_out,
   output reg  [31:0] avs_readdata_out,
   // protocol events from the transceiver core
   input  wire        tx_end_in,
   input  wire        rx_bit_in,
   input  wire        mode_106_ab_in,
   input  wire        rf_field_on_in,
   // gate pins
   input  wire        signal_input_pin_in,
   input  wire        auxiliary_pin_one_in,
   input  wire        address_pin_three_in,
   // status
   output wire        running_flag_out,
   output wire        irq_out
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg  [7:0]             mode_r;
   reg  [7:0]             presc_lo_r;
   reg  [7:0]             reload_hi_r;
   reg  [7:0]             reload_lo_r;
   reg  [2:0]             config_r;
   reg  [`PTU_IRQ_WIDTH-1:0] irq_sts_r;
   reg  [`PTU_IRQ_WIDTH-1:0] irq_mask_r;
   reg  [`PTU_IRQ_WIDTH-1:0] irq_sts_nxt;
   reg  [CNT_W-1:0]       count_r;
   reg  [CNT_W-1:0]       count_nxt;
   reg                    running_r;
   reg                    running_nxt;
   reg  [2:0]             rx_bits_r;
   reg  [2:0]             rx_bits_nxt;
   reg                    ack_r;
   reg  [3:0]             gate_meta_r;
   reg  [3:0]             gate_sync_r;
   reg                    field_prev_r;

   wire                   bus_req;
   wire                   wr_en;
   wire [7:0]             index;
   wire [7:0]             wr_byte;
   wire                   auto_start;
   wire [1:0]             gate_sel;
   wire                   reload_on_zero;
   wire                   receive_multiple;
   wire                   even_divide_select;
   wire                   initial_field_on;
   wire [PRE_W-1:0]       prescaler;
   wire [CNT_W-1:0]       reload_value;
   wire                   stop_now_command;
   wire                   start_now_command;
   wire                   field_rise;
   wire                   start_evt;
   wire                   rx_stop_evt;
   wire                   stop_evt;
   wire                   gate_open;
   wire                   tick;
   wire [2:0]             rx_stop_at;
   wire [2:0]             rx_bits_inc;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one register byte, zero-extended to the bus width
   function [31:0] byte_word;
      input [7:0] val_f;
      begin
         byte_word = {24'h000000, val_f};
      end
   endfunction

   // an accepted write that targets the given register index
   function wr_hit;
      input       en_f;
      input [7:0] idx_f;
      input [7:0] target_f;
      begin
         wr_hit = en_f & (idx_f == target_f);
      end
   endfunction

   // ------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------
   assign auto_start         = mode_r[`PTU_MODE_AUTO_BIT];
   assign gate_sel           = mode_r[`PTU_MODE_GATE_HI:`PTU_MODE_GATE_LO];
   assign reload_on_zero     = mode_r[`PTU_MODE_RELOAD_BIT];
   assign receive_multiple   = config_r[`PTU_CFG_RX_MULTI_BIT];
   assign even_divide_select = config_r[`PTU_CFG_EVEN_DIV_BIT];
   assign initial_field_on   = config_r[`PTU_CFG_INIT_RF_BIT];
   assign prescaler          = {mode_r[`PTU_MODE_PRE_HI:`PTU_MODE_PRE_LO], presc_lo_r};
   assign reload_value       = {reload_hi_r, reload_lo_r};

   // ------------------------------------------------------------
   // avalon slave: one wait cycle, then the answer
   // ------------------------------------------------------------
   // waitrequest drops in the cycle after the request is seen; the write
   // lands on the edge where the master samples it low
   assign bus_req             = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = bus_req & ~ack_r;
   assign wr_en               = avs_write_in & ack_r & avs_byteenable_in[0];
   assign index               = avs_address_in[9:2];
   assign wr_byte             = avs_writedata_in[7:0];

   assign stop_now_command  = wr_hit(wr_en, index, `PTU_IDX_COMMAND) & wr_byte[`PTU_CMD_STOP_BIT];
   assign start_now_command = wr_hit(wr_en, index, `PTU_IDX_COMMAND) & wr_byte[`PTU_CMD_START_BIT];

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // read data captured with the first edge so it stands at the answering edge
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (avs_read_in && !ack_r) begin
         if (index == `PTU_IDX_MODE) begin
            avs_readdata_out <= byte_word(mode_r);
         end else if (index == `PTU_IDX_PRESC) begin
            avs_readdata_out <= byte_word(presc_lo_r);
         end else if (index == `PTU_IDX_RELOAD_HI) begin
            avs_readdata_out <= byte_word(reload_hi_r);
         end else if (index == `PTU_IDX_RELOAD_LO) begin
            avs_readdata_out <= byte_word(reload_lo_r);
         end else if (index == `PTU_IDX_COUNT_HI) begin
            avs_readdata_out <= byte_word(count_r[15:8]);
         end else if (index == `PTU_IDX_COUNT_LO) begin
            avs_readdata_out <= byte_word(count_r[7:0]);
         end else if (index == `PTU_IDX_CONFIG) begin
            avs_readdata_out <= {29'h00000000, config_r};
         end else if (index == `PTU_IDX_STATE) begin
            avs_readdata_out <= {31'h00000000, running_r};
         end else if (index == `PTU_IDX_IRQ_STATUS) begin
            avs_readdata_out <= {29'h00000000, irq_sts_r};
         end else if (index == `PTU_IDX_IRQ_MASK) begin
            avs_readdata_out <= {29'h00000000, irq_mask_r};
         end else begin
            avs_readdata_out <= 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // software-owned registers
   // ------------------------------------------------------------
   // reload bytes may change at any time; the counter only sees them at a start or at a reload on zero
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r      <= `PTU_RST_BYTE;
         presc_lo_r  <= `PTU_RST_BYTE;
         reload_hi_r <= `PTU_RST_BYTE;
         reload_lo_r <= `PTU_RST_BYTE;
         config_r    <= 3'h0;
         irq_mask_r  <= `PTU_RST_IRQ;
      end else if (wr_en) begin
         if (index == `PTU_IDX_MODE) begin
            mode_r <= wr_byte;
         end else if (index == `PTU_IDX_PRESC) begin
            presc_lo_r <= wr_byte;
         end else if (index == `PTU_IDX_RELOAD_HI) begin
            reload_hi_r <= wr_byte;
         end else if (index == `PTU_IDX_RELOAD_LO) begin
            reload_lo_r <= wr_byte;
         end else if (index == `PTU_IDX_CONFIG) begin
            config_r <= wr_byte[2:0];
         end else if (index == `PTU_IDX_IRQ_MASK) begin
            irq_mask_r <= wr_byte[`PTU_IRQ_WIDTH-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   // gate pins and the field detector come from outside this clock
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gate_meta_r  <= 4'h0;
         gate_sync_r  <= 4'h0;
         field_prev_r <= 1'b0;
      end else begin
         gate_meta_r  <= {rf_field_on_in, address_pin_three_in, auxiliary_pin_one_in, signal_input_pin_in};
         gate_sync_r  <= gate_meta_r;
         field_prev_r <= gate_sync_r[3];
      end
   end

   assign field_rise = gate_sync_r[3] & ~field_prev_r;

   // ------------------------------------------------------------
   // gate selection
   // ------------------------------------------------------------
   // gate only holds back decrements; the running flag ignores it
   assign gate_open = (gate_sel == `PTU_GATE_SIGNAL_IN)  ? gate_sync_r[0] :
                      (gate_sel == `PTU_GATE_AUX_ONE)    ? gate_sync_r[1] :
                      (gate_sel == `PTU_GATE_ADDR_THREE) ? gate_sync_r[2] :
                      1'b1;

   // ------------------------------------------------------------
   // start and stop events
   // ------------------------------------------------------------
   // protocol events only count when auto start is on
   assign start_evt = (auto_start & tx_end_in)
                    | (auto_start & initial_field_on & field_rise)
                    | start_now_command;

   assign rx_stop_at  = mode_106_ab_in ? `PTU_RX_STOP_106 : `PTU_RX_STOP_OTHER;
   assign rx_bits_inc = rx_bits_r + 3'h1;

   assign rx_stop_evt = auto_start & ~receive_multiple & running_r
                      & rx_bit_in & (rx_bits_inc == rx_stop_at);

   assign stop_evt = stop_now_command | rx_stop_evt;

   // received bits are counted from the start event onward
   always @* begin
      rx_bits_nxt = rx_bits_r;
      if (start_evt) begin
         rx_bits_nxt = 3'h0;
      end else if (rx_bit_in && running_r && rx_bits_r != 3'h7) begin
         rx_bits_nxt = rx_bits_inc;
      end
   end

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   ptu_prescaler #(
      .PRE_W (PRE_W)
   ) u_presc (
      .mclk_in    (mclk_in),
      .rst_n_in   (rst_n_in),
      .run_in     (running_r),
      .restart_in (start_evt),
      .even_in    (even_divide_select),
      .presc_in   (prescaler),
      .tick_out   (tick)
   );

   // ------------------------------------------------------------
   // down counter
   // ------------------------------------------------------------
   // a stop in the same cycle as a start wins, so software can always halt
   always @* begin
      count_nxt   = count_r;
      running_nxt = running_r;
      irq_sts_nxt = irq_sts_r;
      if (wr_hit(wr_en, index, `PTU_IDX_IRQ_STATUS)) begin
         irq_sts_nxt = irq_sts_r & ~wr_byte[`PTU_IRQ_WIDTH-1:0];
      end
      if (stop_evt) begin
         running_nxt = 1'b0;
         if (rx_stop_evt) begin
            irq_sts_nxt[`PTU_IRQ_RXSTOP_BIT] = 1'b1;
         end
      end else if (start_evt) begin
         count_nxt   = reload_value;
         running_nxt = 1'b1;
         irq_sts_nxt[`PTU_IRQ_START_BIT] = 1'b1;
      end else if (running_r && tick && gate_open) begin
         if (count_r == {CNT_W{1'b0}}) begin
            if (reload_on_zero) begin
               count_nxt = reload_value;
            end else begin
               running_nxt = 1'b0;
               irq_sts_nxt[`PTU_IRQ_EXPIRY_BIT] = 1'b1;
            end
         end else begin
            count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
            if (count_r == {{(CNT_W-1){1'b0}}, 1'b1} && !reload_on_zero) begin
               running_nxt = 1'b0;
               irq_sts_nxt[`PTU_IRQ_EXPIRY_BIT] = 1'b1;
            end
         end
      end
   end

   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_r   <= {CNT_W{1'b0}};
         running_r <= 1'b0;
         rx_bits_r <= 3'h0;
         irq_sts_r <= `PTU_RST_IRQ;
      end else begin
         count_r   <= count_nxt;
         running_r <= running_nxt;
         rx_bits_r <= rx_bits_nxt;
         irq_sts_r <= irq_sts_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign running_flag_out = running_r;
   assign irq_out          = |(irq_sts_r & irq_mask_r);

endmodule

`default_nettype wire

//--- ptu_timer_monitor.sv
// concurrent checks on the ports of the protocol timer unit
`timescale 1ns/1ps
`default_nettype none
module ptu_timer_chk (
   // clock, reset and register bus
   input wire        mclk_in,
   input wire        rst_n_in,
   input wire [9:0]  avs_address_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0]  avs_byteenable_in,
   input wire        avs_waitrequest_out,
   input wire [31:0] avs_readdata_out,
   // events and status
   input wire        tx_end_in,
   input wire        rf_field_on_in,
   input wire        running_flag_out,
   input wire        irq_out
);
   wire req = avs_read_in | avs_write_in;
   // a command write is taken at the edge where waitrequest is seen low
   wire cmd = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0] & (avs_address_in[9:2] == 8'h41);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
      else $error("no wait state in first request cycle");
   a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("more than one wait state");
   a_idle_nowait: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest high while idle");
   a_rdata_upper: assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   a_rdata_hold: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
      else $error("read data changed without a read");
   a_stop_now: assert property (cmd && avs_writedata_in[0] |=> !running_flag_out)
      else $error("stop command did not stop the timer");
   a_soft_start: assert property (cmd && avs_writedata_in[1] && !avs_writedata_in[0] |=> running_flag_out)
      else $error("start command did not start the timer");
   a_start_cause: assert property ($rose(running_flag_out)
      |-> $past(tx_end_in) || $past(cmd) || $past(rf_field_on_in, 2))
      else $error("timer started without a start event");
   c_start: cover property ($rose(running_flag_out));
   c_stop: cover property ($fell(running_flag_out));
   c_irq: cover property ($rose(irq_out));
endmodule
bind ptu_timer ptu_timer_chk u_ptu_timer_chk (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .avs_readdata_out,
   .tx_end_in, .rf_field_on_in, .running_flag_out, .irq_out);
`default_nettype wire

//--- tb.sv
// self-checking bench of the protocol timer unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg         mclk_in = 1'h0;
   reg         rst_n_in = 1'h0;
   reg  [9:0]  avs_address_in = 10'h0;
   reg         avs_read_in = 1'h0;
   reg         avs_write_in = 1'h0;
   reg  [31:0] avs_writedata_in = 32'h0;
   reg  [3:0]  avs_byteenable_in = 4'hF;
   reg         tx_end_in = 1'h0;
   reg         rx_bit_in = 1'h0;
   reg         mode_106_ab_in = 1'h0;
   reg         rf_field_on_in = 1'h0;
   reg  [2:0]  pins = 3'h0;
   wire        avs_waitrequest_out;
   wire [31:0] avs_readdata_out;
   wire        running_flag_out;
   wire        irq_out;
   reg  [7:0]  rd;
   reg  [7:0]  mdl [0:255];
   reg         e;
   integer     err_count = 0, compares = 0, seed = 32'h1841, cyc = 0, t0, i, j, n, p;

   ptu_timer u_ptu_timer (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out, .avs_readdata_out, .tx_end_in,
      .rx_bit_in, .mode_106_ab_in, .rf_field_on_in, .signal_input_pin_in(pins[0]),
      .auxiliary_pin_one_in(pins[1]), .address_pin_three_in(pins[2]), .running_flag_out, .irq_out);

   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // bus, pulse and compare tasks
   // ------------------------------------------------------------
   task give_verdict;
      begin
         $display("compares %0d err_count %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk8(input [7:0] g, input [7:0] x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            err_count = err_count + 1;
            $display("Error %0t: byte %h expected %h", $time, g, x);
         end
      end
   endtask
   task chk1(input g, input x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            err_count = err_count + 1;
            $display("Error %0t: flag %b expected %b", $time, g, x);
         end
      end
   endtask
   task chkn(input integer g, input integer x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            err_count = err_count + 1;
            $display("Error %0t: %0d cycles expected %0d", $time, g, x);
         end
      end
   endtask
   task bus(input w, input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk_in);
         avs_address_in   <= {a, 2'h0};
         avs_writedata_in <= {24'h0, d};
         avs_write_in     <= w;
         avs_read_in      <= ~w;
         // this wait ends when waitrequest is seen low
         do begin
            @(posedge mclk_in);
         end while (avs_waitrequest_out !== 1'h0);
         rd = avs_readdata_out[7:0];
         avs_write_in <= 1'h0;
         avs_read_in  <= 1'h0;
         if (w && avs_byteenable_in[0]) begin
            case (a)
               8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h40, 8'h44: mdl[a] = d;
               8'h43: mdl[a] = mdl[a] & ~d;
               default: ;
            endcase
         end
      end
   endtask
   task rdchk(input [7:0] a, input [7:0] x);
      begin
         bus(1'h0, a, 8'h00);
         chk8(rd, x);
      end
   endtask
   task pulse(input s);
      begin
         @(posedge mclk_in);
         if (s) rx_bit_in <= 1'h1; else tx_end_in <= 1'h1;
         @(posedge mclk_in);
         rx_bit_in <= 1'h0;
         tx_end_in <= 1'h0;
      end
   endtask
   // a negative expectation only asks that the timer has stopped in time
   task waitstop(input integer x);
      integer k;
      begin
         k = 0;
         do begin
            @(posedge mclk_in);
            k = k + 1;
         end while (running_flag_out !== 1'h0 && k < 5000);
         if (x >= 0) chkn(cyc - t0, x); else chk1(running_flag_out, 1'h0);
      end
   endtask

   initial begin
      #400000;
      err_count = err_count + 1;
      $display("Error %0t: timeout", $time);
      give_verdict;
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      for (i = 0; i < 256; i = i + 1) mdl[i] = 8'h00;
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      for (i = 8'h2A; i < 8'h45; i = i + 1) rdchk(i, 8'h00);
      for (i = 8'h2A; i < 8'h2E; i = i + 1) bus(1'h1, i, $random(seed));
      bus(1'h1, 8'h2E, 8'h5A);
      bus(1'h1, 8'h35, 8'hA5);
      avs_byteenable_in <= 4'hE;
      bus(1'h1, 8'h2B, 8'h3C);
      avs_byteenable_in <= 4'hF;
      for (i = 8'h2A; i < 8'h40; i = i + 1) rdchk(i, mdl[i]);
      for (j = 0; j < 6; j = j + 1) begin
         p = (j < 2) ? 0 : (j < 4) ? 3 : 12'h102;
         e = j[0];
         n = 1 + ($random(seed) & 32'h3);
         bus(1'h1, 8'h44, (j == 0) ? 8'h00 : 8'h01);
         bus(1'h1, 8'h40, {6'h0, e, 1'h0});
         bus(1'h1, 8'h2A, {4'h0, p[11:8]});
         bus(1'h1, 8'h2B, p[7:0]);
         bus(1'h1, 8'h2C, 8'h00);
         bus(1'h1, 8'h2D, n[7:0]);
         bus(1'h1, 8'h41, 8'h02);
         t0 = cyc;
         waitstop(n * (2 * p + 1 + e) + 1);
         chk1(irq_out, j != 0);
         rdchk(8'h43, 8'h03);
         rdchk(8'h2F, 8'h00);
         bus(1'h1, 8'h43, 8'h07);
         @(posedge mclk_in);
         chk1(irq_out, 1'h0);
      end
      bus(1'h1, 8'h2B, 8'h00);
      bus(1'h1, 8'h40, 8'h00);
      bus(1'h1, 8'h2A, 8'h00);
      bus(1'h1, 8'h2D, 8'h14);
      bus(1'h1, 8'h41, 8'h02);
      t0 = cyc;
      bus(1'h1, 8'h2D, 8'h02);
      waitstop(21);
      bus(1'h1, 8'h2A, 8'h10);
      bus(1'h1, 8'h2D, 8'h03);
      bus(1'h1, 8'h43, 8'h07);
      bus(1'h1, 8'h41, 8'h02);
      repeat (40) @(posedge mclk_in);
      chk1(running_flag_out, 1'h1);
      bus(1'h1, 8'h41, 8'h01);
      @(posedge mclk_in);
      chk1(running_flag_out, 1'h0);
      rdchk(8'h43, 8'h02);
      bus(1'h1, 8'h2A, 8'h80);
      bus(1'h1, 8'h2C, 8'hFF);
      for (j = 0; j < 2; j = j + 1) begin
         mode_106_ab_in <= j[0];
         bus(1'h1, 8'h43, 8'h07);
         pulse(1'h0);
         repeat (2) @(posedge mclk_in);
         chk1(running_flag_out, 1'h1);
         repeat (3 + j) pulse(1'h1);
         repeat (3) @(posedge mclk_in);
         chk1(running_flag_out, 1'h1);
         pulse(1'h1);
         repeat (3) @(posedge mclk_in);
         chk1(running_flag_out, 1'h0);
         rdchk(8'h43, 8'h06);
      end
      bus(1'h1, 8'h40, 8'h01);
      pulse(1'h0);
      repeat (8) pulse(1'h1);
      chk1(running_flag_out, 1'h1);
      bus(1'h1, 8'h41, 8'h01);
      @(posedge mclk_in);
      chk1(running_flag_out, 1'h0);
      bus(1'h1, 8'h40, 8'h00);
      bus(1'h1, 8'h2A, 8'h00);
      pulse(1'h0);
      repeat (3) @(posedge mclk_in);
      chk1(running_flag_out, 1'h0);
      bus(1'h1, 8'h41, 8'h02);
      repeat (6) pulse(1'h1);
      chk1(running_flag_out, 1'h1);
      bus(1'h1, 8'h41, 8'h01);
      bus(1'h1, 8'h2A, 8'h80);
      bus(1'h1, 8'h40, 8'h04);
      rf_field_on_in <= 1'h1;
      repeat (8) @(posedge mclk_in);
      chk1(running_flag_out, 1'h1);
      bus(1'h1, 8'h41, 8'h01);
      rf_field_on_in <= 1'h0;
      bus(1'h1, 8'h2C, 8'h00);
      for (j = 1; j < 4; j = j + 1) begin
         pins <= $random(seed) & ~(3'h1 << (j - 1));
         bus(1'h1, 8'h2A, {1'h0, j[1:0], 5'h0});
         bus(1'h1, 8'h41, 8'h02);
         repeat (10) @(posedge mclk_in);
         chk1(running_flag_out, 1'h1);
         rdchk(8'h2F, 8'h03);
         pins <= pins | (3'h1 << (j - 1));
         waitstop(-1);
      end
      give_verdict;
   end
endmodule
`default_nettype wire
